// ---- hdl/dgc_global_ctrl.sv ----
// dma global channel control with wishbone register slave
// Function
// - clearing global enable disables channels, aborts active transfers
// - with global enable set, channels run by their own configuration
// - clearing global enable aborts and clears channel pause and trigger bits
// - stopped flag sets after enable cleared and no channel is busy
// - stopped flag sets after nonzero halt and every channel is idle
// - stopped flag clears when enabled and halt is zero
// - software writes to the stopped flag have no effect
// - rotation off: fixed priority, channel 0 highest to 7 lowest
// - rotation on: rotating priority over all eight channels
// - nonzero halt pauses all channels, zero resumes them
// - paused channel ignores transfer requests during the pause
// - requests seen while paused are not remembered; source must re-request
// - halt keeps all channel configuration registers intact
// - global register layout: enable 31, stopped 30, rotate 28, halt 27:24
// - one global register, four registers per channel 0 to 7, plus interrupt status and mask registers
// - channel runs only when both its enable and global enable are set
// - global disable leaves channel enable bits unchanged
`timescale 1ns/1ps
`default_nettype none
module dgc_global_ctrl
  import dgc_pkg::*;
#(
  parameter int NCH = DGC_NCH
) (
  input  wire logic             CLK_SYS_I,   // system clock 200 MHz
  input  wire logic             RST_N_I,     // async reset, active low
  input  wire logic             WB_CYC_I,    // wishbone cycle
  input  wire logic             WB_STB_I,    // wishbone strobe
  input  wire logic             WB_WE_I,     // wishbone write
  input  wire logic [7:0]       WB_ADR_I,    // byte address
  input  wire logic [3:0]       WB_SEL_I,    // byte enables
  input  wire logic [31:0]      WB_DAT_I,    // write data
  output logic      [31:0]      WB_DAT_O,    // read data
  output logic                  WB_ACK_O,    // acknowledge
  input  wire logic [NCH-1:0]   CH_REQ_I,    // channel transfer requests
  input  wire logic [NCH-1:0]   CH_BUSY_I,   // channel mid-transfer
  output logic      [NCH-1:0]   CH_ENABLE_O, // channel may operate
  output logic      [NCH-1:0]   CH_PAUSE_O,  // channel paused
  output logic                  CH_ABORT_O,  // forced stop pulse
  output logic      [NCH-1:0]   CH_GRANT_O,  // one-hot grant pulse
  output logic      [NCH*32-1:0] CH_CFG_A_O, // config a per channel
  output logic      [NCH*32-1:0] CH_CFG_B_O, // config b per channel
  output logic      [NCH*32-1:0] CH_SRC_O,   // source address
  output logic      [NCH*32-1:0] CH_DST_O,   // destination address
  output logic                  IRQ_O        // level interrupt
);
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  localparam int PW = $clog2(NCH);
  localparam int IW = $clog2(NCH*DGC_REGS_CH);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // first set bit of req at or after start, wrapping
  function automatic logic [NCH-1:0] pick(input logic [NCH-1:0] req,
                                          input logic [PW-1:0]  start);
    logic [NCH-1:0] g;
    logic           found;
    logic [PW-1:0]  idx;
    g     = '0;
    found = 1'b0;
    idx   = start;
    for (int i = 0; i < NCH; i++) begin
      if (!found && req[idx]) begin
        g[idx] = 1'b1;
        found  = 1'b1;
      end
      idx = idx + 1'b1;
    end
    return g;
  endfunction : pick

  function automatic logic [PW-1:0] enc(input logic [NCH-1:0] oh);
    logic [PW-1:0] r;
    r = '0;
    for (int i = 0; i < NCH; i++) begin
      if (oh[i]) begin
        r = PW'(i);
      end
    end
    return r;
  endfunction : enc

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic [31:0]       glob_reg;
  logic [31:0]       glob_next;
  logic              stop_reg;
  logic              stop_next;
  logic              arm_reg;
  logic              arm_next;
  logic [31:0]       ch_reg [NCH*DGC_REGS_CH];
  logic              ack_reg;
  logic [31:0]       rdat_reg;
  logic [31:0]       rdat_next;
  logic [NCH-1:0]    grant_reg;
  logic [NCH-1:0]    grant_next;
  logic [PW-1:0]     last_reg;
  logic              abort_reg;
  logic [IRQ_W-1:0]  stat_reg;
  logic [IRQ_W-1:0]  stat_next;
  logic [IRQ_W-1:0]  mask_reg;

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  wire              wb_req   = WB_CYC_I & WB_STB_I & ~ack_reg;
  wire              wr       = wb_req & WB_WE_I;
  wire [7:0]        ch_off   = WB_ADR_I - OFS_CH_BASE;
  wire [IW-1:0]     ch_idx   = ch_off[IW+1:2];
  wire              hit_glob = WB_ADR_I[7:2] == OFS_GLOBAL[7:2];
  wire              hit_ch   = (WB_ADR_I >= OFS_CH_BASE) && (WB_ADR_I < OFS_CH_END);
  wire              hit_stat = WB_ADR_I[7:2] == OFS_IRQ_STAT[7:2];
  wire              hit_mask = WB_ADR_I[7:2] == OFS_IRQ_MASK[7:2];
  wire              wr_glob  = wr & hit_glob;
  // the stopped bit is outside the write mask, so software cannot move it
  wire [31:0]       glob_wv  = merge(glob_reg, WB_DAT_I, WB_SEL_I) & GLOBAL_WMASK;
  wire [31:0]       stat_wv  = merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);
  wire [31:0]       mask_wv  = merge({{(32-IRQ_W){1'b0}}, mask_reg}, WB_DAT_I, WB_SEL_I);

  // ----------------------------------------------------------
  // global fields
  // ----------------------------------------------------------
  wire              g_en     = glob_reg[GB_ENABLE];
  wire              g_rot    = glob_reg[GB_ROTATE];
  wire [3:0]        g_halt   = glob_reg[GB_HALT_HI:GB_HALT_LO];
  wire              g_halted = g_halt != HALT_NONE;
  wire              en_fall  = wr_glob & g_en & ~glob_wv[GB_ENABLE];
  wire              arm_set  = wr_glob & (~glob_wv[GB_ENABLE] |
                               (glob_wv[GB_HALT_HI:GB_HALT_LO] != HALT_NONE));
  wire              run_ok   = g_en & ~g_halted;
  wire              all_idle = ~|CH_BUSY_I;

  assign glob_next = wr_glob ? glob_wv : glob_reg;
  // a disabling or halting write arms the flag even while channels still run
  assign arm_next  = arm_set | (arm_reg & ~run_ok);
  // set once all channels have finished or paused after disable or halt
  assign stop_next = run_ok ? 1'b0 : (stop_reg | (arm_reg & all_idle));

  // ----------------------------------------------------------
  // channel control and arbitration
  // ----------------------------------------------------------
  logic [NCH-1:0] cfg_en;
  logic [NCH-1:0] cfg_pause;
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign cfg_en[c]              = ch_reg[c*DGC_REGS_CH][CA_ENABLE];
    assign cfg_pause[c]           = ch_reg[c*DGC_REGS_CH][CA_PAUSE];
    assign CH_CFG_A_O[c*32 +: 32] = ch_reg[c*DGC_REGS_CH];
    assign CH_CFG_B_O[c*32 +: 32] = ch_reg[c*DGC_REGS_CH+1];
    assign CH_SRC_O[c*32 +: 32]   = ch_reg[c*DGC_REGS_CH+2];
    assign CH_DST_O[c*32 +: 32]   = ch_reg[c*DGC_REGS_CH+3];
  end

  assign CH_ENABLE_O = cfg_en & {NCH{g_en}};
  assign CH_PAUSE_O  = cfg_pause | {NCH{g_halted}};
  // a request counts only in the cycle it is seen; nothing latches it
  wire [NCH-1:0] elig  = CH_REQ_I & CH_ENABLE_O & ~CH_PAUSE_O;
  wire [PW-1:0]  start = g_rot ? PW'(last_reg + 1'b1) : '0;
  wire           can_g = all_idle & ~|grant_reg & ~en_fall;

  assign grant_next = can_g ? pick(elig, start) : '0;
  assign CH_GRANT_O = grant_reg;
  assign CH_ABORT_O = abort_reg;

  // ----------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------
  wire [IRQ_W-1:0] irq_ev  = {en_fall, stop_next & ~stop_reg};
  wire [IRQ_W-1:0] irq_clr = (wr & hit_stat) ? stat_wv[IRQ_W-1:0] : '0;
  // a new event beats a clear in the same cycle
  assign stat_next = (stat_reg & ~irq_clr) | irq_ev;
  assign IRQ_O     = |(stat_reg & mask_reg);

  // ----------------------------------------------------------
  // read mux
  // ----------------------------------------------------------
  wire [31:0] glob_rd = glob_reg | ({31'h0000_0000, stop_reg} << GB_STOPPED);
  assign rdat_next = hit_glob ? glob_rd :
                     hit_ch   ? ch_reg[ch_idx] :
                     hit_stat ? {{(32-IRQ_W){1'b0}}, stat_reg} :
                     hit_mask ? {{(32-IRQ_W){1'b0}}, mask_reg} :
                                32'h0000_0000;
  assign WB_DAT_O = rdat_reg;
  assign WB_ACK_O = ack_reg;

  // ----------------------------------------------------------
  // flops
  // ----------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      glob_reg  <= GLOBAL_RST;
      stop_reg  <= 1'b0;
      arm_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      rdat_reg  <= 32'h0000_0000;
      stat_reg  <= IRQ_RST;
      mask_reg  <= IRQ_RST;
      abort_reg <= 1'b0;
    end else begin
      glob_reg  <= glob_next;
      stop_reg  <= stop_next;
      arm_reg   <= arm_next;
      ack_reg   <= wb_req;
      rdat_reg  <= wb_req ? rdat_next : rdat_reg;
      stat_reg  <= stat_next;
      mask_reg  <= (wr & hit_mask) ? mask_wv[IRQ_W-1:0] : mask_reg;
      abort_reg <= en_fall;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      grant_reg <= '0;
      last_reg  <= '0;
    end else begin
      grant_reg <= grant_next;
      last_reg  <= |grant_next ? enc(grant_next) : last_reg;
    end
  end

  // forced disable clears pause and trigger but keeps each enable bit;
  // halt never touches these registers
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < NCH*DGC_REGS_CH; i++) begin
        ch_reg[i] <= CH_RST;
      end
    end else if (en_fall) begin
      for (int c = 0; c < NCH; c++) begin
        ch_reg[c*DGC_REGS_CH][CA_PAUSE]  <= 1'b0;
        ch_reg[c*DGC_REGS_CH][CA_SWTRIG] <= 1'b0;
      end
    end else if (wr & hit_ch) begin
      ch_reg[ch_idx] <= merge(ch_reg[ch_idx], WB_DAT_I, WB_SEL_I);
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  property p_abort_pulse;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      en_fall |=> CH_ABORT_O ##1 !CH_ABORT_O;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse wrong");

  property p_no_grant_off;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      !g_en |=> CH_GRANT_O == '0;
  endproperty
  a_no_grant_off: assert property (p_no_grant_off) else $error("grant while disabled");

  property p_grant_when_run;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (|elig && can_g) |=> |CH_GRANT_O;
  endproperty
  a_grant_when_run: assert property (p_grant_when_run) else $error("eligible request not granted");

  property p_abort_clears;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      en_fall |=> (CH_CFG_A_O[CA_PAUSE] == 1'b0) &&
                  (CH_CFG_A_O[CA_ENABLE] == $past(CH_CFG_A_O[CA_ENABLE]));
  endproperty
  a_abort_clears: assert property (p_abort_clears) else $error("config not reset on abort");

  property p_stop_set;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (arm_reg && all_idle && !run_ok) |=> stop_reg;
  endproperty
  a_stop_set: assert property (p_stop_set) else $error("stopped flag not set");

  property p_stop_clr;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      run_ok |=> !stop_reg ##1 (stop_reg -> $past(!run_ok));
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stopped flag not cleared");

  property p_fixed_prio;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (can_g && !g_rot && |elig) |=> CH_GRANT_O == ($past(elig) & (~$past(elig) + 1'b1));
  endproperty
  a_fixed_prio: assert property (p_fixed_prio) else $error("fixed priority order broken");

  property p_onehot;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $onehot0(CH_GRANT_O);
  endproperty
  a_onehot: assert property (p_onehot) else $error("grant not one-hot");

  property p_halt_blocks;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      g_halted |=> CH_GRANT_O == '0;
  endproperty
  a_halt_blocks: assert property (p_halt_blocks) else $error("grant during halt");

  property p_halt_keeps;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (wr_glob && !en_fall) |=> $stable(CH_CFG_A_O);
  endproperty
  a_halt_keeps: assert property (p_halt_keeps) else $error("halt changed config");

  property p_rotate;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (can_g && g_rot && elig[PW'(last_reg + 1'b1)]) |=> CH_GRANT_O[$past(PW'(last_reg + 1'b1))];
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotation order broken");

  property p_ack_answer;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

  property p_ack_pulse;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

  property p_stop_ro;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (!run_ok && !arm_reg && !stop_reg) |=> !stop_reg;
  endproperty
  a_stop_ro: assert property (p_stop_ro) else $error("stopped flag set without arming");

  property p_stop_rise;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(stop_reg) |-> $past(all_idle) && $past(arm_reg);
  endproperty
  a_stop_rise: assert property (p_stop_rise) else $error("stopped flag rose while busy");

  property p_abort_source;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      CH_ABORT_O |-> $past(en_fall);
  endproperty
  a_abort_source: assert property (p_abort_source) else $error("abort without disable");

  property p_abort_keeps_en;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      en_fall |=> cfg_en == $past(cfg_en);
  endproperty
  a_abort_keeps_en: assert property (p_abort_keeps_en) else $error("disable changed channel enables");

  property p_halt_pause;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      g_halted |-> CH_PAUSE_O == {NCH{1'b1}};
  endproperty
  a_halt_pause: assert property (p_halt_pause) else $error("halt did not pause all");

  property p_paused_no_grant;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      |CH_PAUSE_O |=> (CH_GRANT_O & $past(CH_PAUSE_O)) == '0;
  endproperty
  a_paused_no_grant: assert property (p_paused_no_grant) else $error("paused channel granted");

  property p_grant_enabled;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      |CH_REQ_I |=> (CH_GRANT_O & ~$past(CH_ENABLE_O)) == '0;
  endproperty
  a_grant_enabled: assert property (p_grant_enabled) else $error("disabled channel granted");

  property p_rot_last;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      |CH_GRANT_O |-> CH_GRANT_O[last_reg];
  endproperty
  a_rot_last: assert property (p_rot_last) else $error("last granted not recorded");
endmodule : dgc_global_ctrl
`default_nettype wire

// ---- hdl/dgc_pkg.sv ----
// constants for the dma global channel control block
package dgc_pkg;
  // ----------------------------------------------------------
  // geometry
  // ----------------------------------------------------------
  localparam int          DGC_NCH       = 8;
  localparam int          DGC_ADR_W     = 8;
  localparam int          DGC_REGS_CH   = 4;
  // ----------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------
  localparam logic [7:0]  OFS_GLOBAL    = 8'h00;
  localparam logic [7:0]  OFS_CH_BASE   = 8'h40;
  localparam logic [7:0]  OFS_CH_END    = 8'hC0;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'hC0;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'hC4;
  // ----------------------------------------------------------
  // global control fields
  // ----------------------------------------------------------
  localparam int          GB_ENABLE     = 31;
  localparam int          GB_STOPPED    = 30;
  localparam int          GB_ROTATE     = 28;
  localparam int          GB_HALT_HI    = 27;
  localparam int          GB_HALT_LO    = 24;
  localparam logic [31:0] GLOBAL_RST    = 32'h0000_0000;
  localparam logic [31:0] GLOBAL_WMASK  = 32'h9F00_0000;
  localparam logic [3:0]  HALT_NONE     = 4'h0;
  // ----------------------------------------------------------
  // channel config a fields
  // ----------------------------------------------------------
  localparam int          CA_ENABLE     = 31;
  localparam int          CA_PAUSE      = 30;
  localparam int          CA_SWTRIG     = 29;
  localparam logic [31:0] CH_RST        = 32'h0000_0000;
  // ----------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------
  localparam int          IRQ_W         = 2;
  localparam int          IRQ_STOPPED   = 0;
  localparam int          IRQ_ABORT     = 1;
  localparam logic [1:0]  IRQ_RST       = 2'h0;
endpackage : dgc_pkg

// ---- verif/dgc_chan_model.sv ----
// model of the eight channel engines behind the global control
`timescale 1ns/1ps
`default_nettype none
module dgc_chan_model
  import dgc_pkg::*;
(
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_n_i, // async reset, active low
  input  wire logic [7:0] grant_i, // one-hot grant
  input  wire logic       abort_i, // forced stop
  input  wire logic [7:0] pause_i, // per channel pause
  input  wire logic [7:0] len_i,   // transfer length in cycles
  output logic      [7:0] busy_o   // channel mid-transfer
);
  logic [7:0] cnt_reg [DGC_NCH];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    for (int c = 0; c < DGC_NCH; c++) begin
      if (!rst_n_i)
        cnt_reg[c] <= 8'h00;
      else if (abort_i)
        cnt_reg[c] <= 8'h00;
      else if (grant_i[c])
        cnt_reg[c] <= len_i;
      else if (pause_i[c])
        cnt_reg[c] <= 8'h00;
      else if (cnt_reg[c] != 8'h00)
        cnt_reg[c] <= cnt_reg[c] - 8'h01;
    end
  end
  // a parked transfer is dropped: only a fresh request restarts it
  always_comb begin
    for (int c = 0; c < DGC_NCH; c++)
      busy_o[c] = (cnt_reg[c] != 8'h00);
  end
endmodule : dgc_chan_model
`default_nettype wire

// ---- verif/dgc_global_ctrl_tb.sv ----
// self-checking bench for the dma global channel control
`timescale 1ns/1ps
`default_nettype none
module dgc_global_ctrl_tb
  import dgc_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [3:0]   sel = 4'h0;
  logic [31:0]  wdat = 32'h0;
  logic [31:0]  rdat;
  logic         ack;
  logic [7:0]   req = 8'h00;
  logic [7:0]   len = 8'h03;
  logic [7:0]   busy;
  logic [7:0]   ch_en;
  logic [7:0]   ch_pause;
  logic         abort;
  logic [7:0]   grant;
  logic         irq;
  logic [255:0] cfg_a;
  logic [255:0] cfg_b;
  logic [255:0] src;
  logic [255:0] dst;
  int           errors = 0;
  int           samples_checked = 0;
  int           aborts = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (abort === 1'b1) aborts++;
  dgc_global_ctrl #(.NCH(DGC_NCH)) i_dgc_global_ctrl (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CH_REQ_I(req), .CH_BUSY_I(busy), .CH_ENABLE_O(ch_en), .CH_PAUSE_O(ch_pause),
    .CH_ABORT_O(abort), .CH_GRANT_O(grant), .CH_CFG_A_O(cfg_a), .CH_CFG_B_O(cfg_b), .CH_SRC_O(src),
    .CH_DST_O(dst), .IRQ_O(irq));
  dgc_chan_model i_dgc_chan_model (.clk_i(clk), .rst_n_i(rst_n), .grant_i(grant),
    .abort_i(abort), .pause_i(ch_pause), .len_i(len), .busy_o(busy));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    chk({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  function automatic logic [7:0] cfg_adr(input int c, input int k);
    return OFS_CH_BASE + 8'(c * 16 + k * 4);
  endfunction : cfg_adr
  task automatic wait_grant(output logic [7:0] g);
    g = 8'h00;
    for (int n = 0; n < 30 && g === 8'h00; n++) begin
      @(posedge clk);
      g = grant;
    end
  endtask : wait_grant
  // drop requests long enough for any pending grant to pass
  task automatic set_req(input logic [7:0] v);
    @(posedge clk);
    req <= 8'h00;
    repeat (8) @(posedge clk);
    req <= v;
  endtask : set_req
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    rd(OFS_GLOBAL, GLOBAL_RST);
    wr(OFS_GLOBAL, 32'h7FFF_FFFF);
    repeat (4) @(posedge clk);
    rd(OFS_GLOBAL, 32'h5F00_0000);
    wr(OFS_GLOBAL, 32'h0000_0000);
    rd(OFS_GLOBAL, 32'h4000_0000);
    for (int i = 0; i < 32; i++) wr(cfg_adr(i / 4, i % 4), {16'h0012, 8'h34, cfg_adr(i / 4, i % 4)});
    for (int i = 0; i < 32; i++) rd(cfg_adr(i / 4, i % 4), {16'h0012, 8'h34, cfg_adr(i / 4, i % 4)});
    for (int c = 0; c < 8; c++) begin
      chk(cfg_a[c*32 +: 32], {16'h0012, 8'h34, cfg_adr(c, 0)});
      chk(cfg_b[c*32 +: 32], {16'h0012, 8'h34, cfg_adr(c, 1)});
      chk(src[c*32 +: 32], {16'h0012, 8'h34, cfg_adr(c, 2)});
      chk(dst[c*32 +: 32], {16'h0012, 8'h34, cfg_adr(c, 3)});
    end
    wr(8'hF0, 32'hFFFF_FFFF);
    rd(8'hF0, 32'h0);
    $display("done registers");
  endtask : t_regs
  task automatic t_fixed;
    logic [7:0] g;
    wr(OFS_GLOBAL, 32'h8000_0000);
    for (int c = 0; c < 8; c++) wr(cfg_adr(c, 0), 32'h8000_0000);
    rd(OFS_GLOBAL, 32'h8000_0000);
    chk({24'h0, ch_en}, 32'hFF);
    for (int i = 0; i < 8; i++) begin
      set_req(8'hFF << i);
      wait_grant(g);
      chk({24'h0, g}, 32'h1 << i);
    end
    wr(cfg_adr(0, 0), 32'h0);
    set_req(8'h01);
    wait_grant(g);
    chk({24'h0, g}, 32'h0);
    wr(cfg_adr(0, 0), 32'h8000_0000);
    $display("done fixed priority");
  endtask : t_fixed
  task automatic t_rotate;
    logic [7:0] g;
    logic [7:0] p;
    wr(OFS_GLOBAL, 32'h9000_0000);
    set_req(8'hFF);
    wait_grant(p);
    for (int i = 0; i < 9; i++) begin
      wait_grant(g);
      chk({24'h0, g}, {24'h0, p[6:0], p[7]});
      p = g;
    end
    set_req(8'h00);
    wr(OFS_GLOBAL, 32'h8000_0000);
    $display("done rotating priority");
  endtask : t_rotate
  task automatic t_halt;
    logic [7:0] g;
    len <= 8'h28;
    set_req(8'h08);
    wait_grant(g);
    chk({24'h0, g}, 32'h08);
    wr(OFS_GLOBAL, 32'h8500_0000);
    chk({24'h0, ch_pause}, 32'hFF);
    repeat (4) @(posedge clk);
    rd(OFS_GLOBAL, 32'hC500_0000);
    set_req(8'hFF);
    wait_grant(g);
    chk({24'h0, g}, 32'h0);
    rd(cfg_adr(3, 0), 32'h8000_0000);
    // short transfers again so the re-request is served inside the wait
    len <= 8'h03;
    wr(OFS_GLOBAL, 32'h8000_0000);
    chk({24'h0, ch_pause}, 32'h0);
    rd(OFS_GLOBAL, 32'h8000_0000);
    wait_grant(g);
    chk({24'h0, g}, 32'h01);
    set_req(8'h00);
    $display("done halt");
  endtask : t_halt
  task automatic t_disable;
    logic [7:0] g;
    wr(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_MASK, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(cfg_adr(2, 0), 32'hC000_0000);
    set_req(8'h02);
    wait_grant(g);
    aborts = 0;
    wr(OFS_GLOBAL, 32'h0);
    repeat (4) @(posedge clk);
    chk(aborts, 32'h1);
    chk({24'h0, ch_en}, 32'h0);
    rd(OFS_GLOBAL, 32'h4000_0000);
    rd(cfg_adr(2, 0), 32'h8000_0000);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_STAT, 32'h3);
    rd(OFS_IRQ_STAT, 32'h0);
    set_req(8'hFF);
    wait_grant(g);
    chk({24'h0, g}, 32'h0);
    wr(OFS_GLOBAL, 32'h8000_0000);
    chk({24'h0, ch_en}, 32'hFF);
    set_req(8'h00);
    $display("done forced disable");
  endtask : t_disable
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({24'h0, ch_en}, 32'h0);
    chk({24'h0, grant}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rst_n <= 1'b1;
    rd(OFS_GLOBAL, GLOBAL_RST);
    rd(cfg_adr(5, 0), CH_RST);
    $display("done reset");
  endtask : t_reset
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_fixed;
    t_rotate;
    t_halt;
    t_disable;
    t_reset;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim;
  end
endmodule : dgc_global_ctrl_tb
`default_nettype wire
